// file: otfrc_pmbus_regs.sv
// Over-temperature fault response, thresholds and management-link slave
`timescale 1ns/1ns
`default_nettype none

module otfrc_pmbus_regs #(
  parameter logic [6:0] SLAVE_ADDR        = otfrc_pkg::DEFAULT_SLAVE_ADDR,
  parameter int         RETRY_UNIT_CYCLES = otfrc_pkg::RETRY_UNIT_CYCLES
) (
  input  wire logic                                       sys_clk,
  input  wire logic                                       rstn,
  input  wire logic                                       scl,
  input  wire logic                                       sda_in,
  output var  logic                                       sda_out,
  output var  logic                                       sda_oe_n,
  output var  logic                                       alert_line_n,
  input  wire logic [otfrc_pkg::NUM_PAGES-1:0]            enable_pin,
  input  wire logic [otfrc_pkg::NUM_PAGES-1:0]            ot_fault_in,
  input  wire logic [otfrc_pkg::NUM_PAGES-1:0]            ot_warn_in,
  output var  logic [otfrc_pkg::NUM_PAGES-1:0]            output_on,
  output var  otfrc_pkg::otfrc_page_cfg_t [otfrc_pkg::NUM_PAGES-1:0] page_cfg,
  output var  otfrc_pkg::otfrc_linear11_t                 vin_ov_threshold
);

  localparam int NP = otfrc_pkg::NUM_PAGES;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [otfrc_pkg::SYNC_W-1:0] sync_ff1;
  logic [otfrc_pkg::SYNC_W-1:0] sync_ff2;
  logic                         scl_d;
  logic                         sda_d;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_ff1 <= otfrc_pkg::SYNC_W'(2'b11); // Link lines idle high, pins low
      sync_ff2 <= otfrc_pkg::SYNC_W'(2'b11);
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      sync_ff1 <= {ot_warn_in, ot_fault_in, enable_pin, sda_in, scl};
      sync_ff2 <= sync_ff1;
      scl_d    <= sync_ff2[0];
      sda_d    <= sync_ff2[1];
    end
  end

  wire          scl_s   = sync_ff2[0];
  wire          sda_s   = sync_ff2[1];
  wire [NP-1:0] en_s    = sync_ff2[2 +: NP];
  wire [NP-1:0] fault_s = sync_ff2[2+NP +: NP];
  wire [NP-1:0] warn_s  = sync_ff2[2+2*NP +: NP];

  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Link byte engine
  // ----------------------------------------------------------------
  otfrc_pkg::otfrc_bus_t phase;
  logic [3:0]            bit_cnt;
  logic [7:0]            shreg;
  logic [7:0]            tx;
  logic [7:0]            cmd;
  logic [7:0]            wr_lo;
  logic                  byte_idx;
  logic [7:0]            page;
  logic [15:0]           rd_word;

  wire pg         = page[0];
  wire byte_done  = scl_fall & (bit_cnt == 4'd7);
  wire addr_match = (shreg[7:1] == SLAVE_ADDR);
  wire cmd_done   = byte_done & (phase == otfrc_pkg::BUS_CMD);
  wire wr_byte0   = byte_done & (phase == otfrc_pkg::BUS_WR) & ~byte_idx;
  wire wr_byte1   = byte_done & (phase == otfrc_pkg::BUS_WR) & byte_idx;
  wire clear_stb  = cmd_done & (shreg == otfrc_pkg::CMD_CLEAR_FAULTS);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase    <= otfrc_pkg::BUS_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      cmd      <= 8'h00;
      byte_idx <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (start_cond) begin
      phase    <= otfrc_pkg::BUS_ADDR;
      bit_cnt  <= 4'd8; // Clock fall closing the start is no data bit
      sda_oe_n <= 1'b1;
    end else if (stop_cond) begin
      phase    <= otfrc_pkg::BUS_IDLE;
      sda_oe_n <= 1'b1;
    end else if (phase != otfrc_pkg::BUS_IDLE) begin
      if (scl_rise) begin
        shreg <= {shreg[6:0], sda_s};
        // Master not-acknowledge ends a read
        if (phase == otfrc_pkg::BUS_RD && bit_cnt == 4'd8 && sda_s) begin
          phase <= otfrc_pkg::BUS_IDLE;
        end
      end
      if (scl_fall) begin
        if (bit_cnt == 4'd7) begin
          bit_cnt <= 4'd8;
          unique case (phase)
            otfrc_pkg::BUS_ADDR: begin
              byte_idx <= 1'b0;
              tx       <= rd_word[7:0];
              sda_oe_n <= ~addr_match;
              if (!addr_match) begin
                phase <= otfrc_pkg::BUS_IDLE;
              end else if (shreg[0]) begin
                phase <= otfrc_pkg::BUS_RD;
              end else begin
                phase <= otfrc_pkg::BUS_CMD;
              end
            end
            otfrc_pkg::BUS_CMD: begin
              cmd      <= shreg;
              byte_idx <= 1'b0;
              phase    <= otfrc_pkg::BUS_WR;
              sda_oe_n <= 1'b0;
            end
            otfrc_pkg::BUS_WR: begin
              byte_idx <= 1'b1;
              sda_oe_n <= 1'b0;
            end
            otfrc_pkg::BUS_RD: begin
              tx       <= byte_idx ? 8'h00 : rd_word[15:8];
              byte_idx <= 1'b1;
              sda_oe_n <= 1'b1;
            end
            default: begin
              sda_oe_n <= 1'b1;
            end
          endcase
        end else begin
          bit_cnt <= (bit_cnt == 4'd8) ? 4'h0 : bit_cnt + 4'h1;
          if (phase == otfrc_pkg::BUS_RD) begin
            sda_oe_n <= tx[7];
            tx       <= {tx[6:0], 1'b0};
          end else begin
            sda_oe_n <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [NP-1:0] fault_flag;
  logic [NP-1:0] warn_flag;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      page             <= otfrc_pkg::PAGE_RESET;
      wr_lo            <= 8'h00;
      vin_ov_threshold <= otfrc_pkg::VIN_OV_THRESH_RESET;
      sda_out          <= 1'b0;
    end else begin
      if (wr_byte0) begin
        wr_lo <= shreg;
      end
      if (wr_byte0 && cmd == otfrc_pkg::CMD_PAGE) begin
        page <= shreg;
      end
      // Single global copy, not steered by the page selector
      if (wr_byte1 && cmd == otfrc_pkg::CMD_VIN_OV_THRESH) begin
        vin_ov_threshold <= {shreg, wr_lo};
      end
    end
  end

  wire [7:0] status_temp = {fault_flag[pg], warn_flag[pg], 6'h00};
  wire [7:0] status_low  = {5'h00, fault_flag[pg] | warn_flag[pg], 2'b00};

  assign rd_word =
    (cmd == otfrc_pkg::CMD_PAGE)            ? {8'h00, page} :
    (cmd == otfrc_pkg::CMD_OT_FAULT_ACTION) ? {8'h00, page_cfg[pg].fault_action} :
    (cmd == otfrc_pkg::CMD_OT_WARN_THRESH)  ? page_cfg[pg].warn_threshold :
    (cmd == otfrc_pkg::CMD_VIN_OV_THRESH)   ? vin_ov_threshold :
    (cmd == otfrc_pkg::CMD_STATUS_WORD)     ? {8'h00, status_low} :
    (cmd == otfrc_pkg::CMD_STATUS_TEMP)     ? {8'h00, status_temp} : 16'h0000;

  // ----------------------------------------------------------------
  // Per-page configuration, flags and restart sequencer
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_page
      otfrc_pkg::otfrc_page_state_t  state;
      logic [otfrc_pkg::UNIT_CNT_W-1:0] unit_cnt;
      logic [2:0]                       delay_cnt;

      wire [1:0] resp   = page_cfg[p].fault_action[otfrc_pkg::RESP_HI:otfrc_pkg::RESP_LO];
      wire [2:0] retry  = page_cfg[p].fault_action[otfrc_pkg::RETRY_HI:otfrc_pkg::RETRY_LO];
      wire [2:0] delay  = page_cfg[p].fault_action[otfrc_pkg::DELAY_HI:0];
      wire       sel    = (pg == 1'(p));
      wire       trip   = (state == otfrc_pkg::PG_ON) & en_s[p] & fault_s[p];
      wire       unit_end = (unit_cnt == '0);
      wire       do_hold  = (resp == otfrc_pkg::RESP_RETRY) &
                            (retry == otfrc_pkg::RETRY_CONTINUOUS);

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          page_cfg[p].fault_action   <= otfrc_pkg::OT_FAULT_ACTION_RESET;
          page_cfg[p].warn_threshold <= otfrc_pkg::OT_WARN_THRESH_RESET;
        end else begin
          if (wr_byte0 && sel && cmd == otfrc_pkg::CMD_OT_FAULT_ACTION) begin
            page_cfg[p].fault_action <= shreg;
          end
          if (wr_byte1 && sel && cmd == otfrc_pkg::CMD_OT_WARN_THRESH) begin
            page_cfg[p].warn_threshold <= {shreg, wr_lo};
          end
        end
      end

      // Set beats clear so an event landing on a clear is kept
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          fault_flag[p] <= 1'b0;
          warn_flag[p]  <= 1'b0;
        end else begin
          fault_flag[p] <= trip | (fault_flag[p] & ~clear_stb);
          warn_flag[p]  <= warn_s[p] | (warn_flag[p] & ~clear_stb);
        end
      end

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          state     <= otfrc_pkg::PG_ON;
          unit_cnt  <= '0;
          delay_cnt <= 3'h0;
          output_on[p] <= 1'b0;
        end else begin
          output_on[p] <= (state == otfrc_pkg::PG_ON) & en_s[p] & ~fault_s[p];
          unique case (state)
            otfrc_pkg::PG_ON: begin
              if (trip) begin
                unit_cnt  <= otfrc_pkg::UNIT_CNT_W'(RETRY_UNIT_CYCLES - 1);
                delay_cnt <= delay;
                if (resp == otfrc_pkg::RESP_WHILE_FAULT) begin
                  state <= otfrc_pkg::PG_COOL;
                end else if (do_hold) begin
                  state <= otfrc_pkg::PG_HOLD;
                end else begin
                  state <= otfrc_pkg::PG_LATCH;
                end
              end
            end
            otfrc_pkg::PG_HOLD: begin
              // Commanded off ends the retry loop
              if (!en_s[p]) begin
                state <= otfrc_pkg::PG_ON;
              end else if (unit_end) begin
                unit_cnt <= otfrc_pkg::UNIT_CNT_W'(RETRY_UNIT_CYCLES - 1);
                if (delay_cnt == 3'h0) begin
                  state <= otfrc_pkg::PG_ON;
                end else begin
                  delay_cnt <= delay_cnt - 3'h1;
                end
              end else begin
                unit_cnt <= unit_cnt - 1'b1;
              end
            end
            otfrc_pkg::PG_LATCH: begin
              // Only a restart through the enable pin clears the latch
              if (!en_s[p]) begin
                state <= otfrc_pkg::PG_ON;
              end
            end
            otfrc_pkg::PG_COOL: begin
              if (!fault_s[p] && !warn_s[p]) begin
                state <= otfrc_pkg::PG_ON;
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Alert
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_line_n <= 1'b1;
    end else begin
      alert_line_n <= ~(|fault_flag | |warn_flag);
    end
  end

endmodule

`default_nettype wire

// file: otfrc_pkg.sv
// Package for the over-temperature fault response and threshold register block
package otfrc_pkg;

  // ----------------------------------------------------------------
  // Pages, commands and slave address
  // ----------------------------------------------------------------
  localparam int         NUM_PAGES           = 2;
  localparam logic [6:0] DEFAULT_SLAVE_ADDR  = 7'h20; // Arbitrary value
  localparam logic [7:0] CMD_PAGE            = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS    = 8'h03;
  localparam logic [7:0] CMD_OT_FAULT_ACTION = 8'h50;
  localparam logic [7:0] CMD_OT_WARN_THRESH  = 8'h51;
  localparam logic [7:0] CMD_VIN_OV_THRESH   = 8'h55;
  localparam logic [7:0] CMD_STATUS_WORD     = 8'h79;
  localparam logic [7:0] CMD_STATUS_TEMP     = 8'h7d;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PAGE_RESET            = 8'h00;
  localparam logic [7:0]  OT_FAULT_ACTION_RESET = 8'hff;
  localparam logic [15:0] OT_WARN_THRESH_RESET  = 16'heb70;
  localparam logic [15:0] VIN_OV_THRESH_RESET   = 16'hd3e0;

  // ----------------------------------------------------------------
  // Field positions and encodings
  // ----------------------------------------------------------------
  localparam int         RESP_HI           = 7;
  localparam int         RESP_LO           = 6;
  localparam int         RETRY_HI          = 5;
  localparam int         RETRY_LO          = 3;
  localparam int         DELAY_HI          = 2;
  localparam logic [1:0] RESP_RETRY        = 2'b10;
  localparam logic [1:0] RESP_WHILE_FAULT  = 2'b11;
  localparam logic [2:0] RETRY_NONE        = 3'b000;
  localparam logic [2:0] RETRY_CONTINUOUS  = 3'b111;
  localparam int         STATUS_WORD_TEMP  = 2;
  localparam int         STATUS_T_OT_WARN  = 6;
  localparam int         STATUS_T_OT_FAULT = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 100;
  localparam int RETRY_UNIT_MS     = 35;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * 1000 * CLK_MHZ;
  localparam int UNIT_CNT_W        = 22;
  localparam int SYNC_W            = 2 + 3 * NUM_PAGES;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [4:0]  exponent;
    logic signed [10:0] mantissa;
  } otfrc_linear11_t;

  typedef struct packed {
    logic [7:0]      fault_action;
    otfrc_linear11_t warn_threshold;
  } otfrc_page_cfg_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_CMD  = 3'b010,
    BUS_WR   = 3'b011,
    BUS_RD   = 3'b100
  } otfrc_bus_t;

  typedef enum logic [1:0] {
    PG_ON    = 2'b00,
    PG_HOLD  = 2'b01,
    PG_LATCH = 2'b10,
    PG_COOL  = 2'b11
  } otfrc_page_state_t;

endpackage

// file: otfrc_assertions.sv
// Port checker for fault sequencing and alert behaviour
`timescale 1ns/1ns
`default_nettype none

module otfrc_assertions #(
  parameter int RETRY_UNIT_CYCLES = 20
) (
  input wire logic                                              sys_clk,
  input wire logic                                              rstn,
  input wire logic                                              scl,
  input wire logic                                              sda_in,
  input wire logic                                              sda_out,
  input wire logic                                              sda_oe_n,
  input wire logic                                              alert_line_n,
  input wire logic [otfrc_pkg::NUM_PAGES-1:0]                   enable_pin,
  input wire logic [otfrc_pkg::NUM_PAGES-1:0]                   ot_fault_in,
  input wire logic [otfrc_pkg::NUM_PAGES-1:0]                   ot_warn_in,
  input wire logic [otfrc_pkg::NUM_PAGES-1:0]                   output_on,
  input wire otfrc_pkg::otfrc_page_cfg_t [otfrc_pkg::NUM_PAGES-1:0] page_cfg,
  input wire otfrc_pkg::otfrc_linear11_t                        vin_ov_threshold
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  wire logic [7:0] act0   = page_cfg[0].fault_action;
  wire logic [7:0] act1   = page_cfg[1].fault_action;
  wire logic       hold0  = act0[7:6] == 2'b11;
  wire logic       latch0 = !hold0 && !(act0[7:6] == 2'b10 && act0[5:3] == 3'b111);
  wire logic       cont1  = act1[7:6] == 2'b10 && act1[5:3] == 3'b111;
  int              gap1;
  int              off_cnt;
  logic            armed;

  assign gap1 = (int'(act1[2:0]) + 1) * RETRY_UNIT_CYCLES;

  // Armed only for falls seen with the enable held, so enable restarts are not timed
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      off_cnt <= 0;
      armed <= 1'b0;
    end else begin
      off_cnt <= output_on[1] ? 0 : off_cnt + 1;
      armed <= enable_pin[1] && (armed || $fell(output_on[1]));
    end
  end

  sequence s_off8;
    !output_on[0] [*8];
  endsequence
  sequence s_clear6;
    (hold0 && enable_pin[0] && !ot_fault_in[0] && !ot_warn_in[0]) [*6];
  endsequence

  trip_off_a: assert property (output_on[0] && ot_fault_in[0] |-> ##[1:5] !output_on[0])
    else $error("page 0 output stayed on during fault");
  trip_off1_a: assert property (output_on[1] && ot_fault_in[1] |-> ##[1:5] !output_on[1])
    else $error("page 1 output stayed on during fault");
  alert_fault_a: assert property (output_on[1] && ot_fault_in[1] |-> ##[1:6] !alert_line_n)
    else $error("alert not raised on fault");
  alert_warn_a: assert property (ot_warn_in[0] [*4] |-> ##[0:3] !alert_line_n)
    else $error("alert not raised on warning");
  latch_hold_a: assert property ($fell(output_on[0]) && latch0 |-> s_off8 ##1 s_off8 ##1 s_off8)
    else $error("latched output restarted");
  retry_gap_a: assert property ($rose(output_on[1]) && armed && cont1 |->
    off_cnt >= gap1 - 4 && off_cnt <= gap1 + 4)
    else $error("restart interval wrong");
  hold_fault_a: assert property ((hold0 && !output_on[0] && ot_warn_in[0]) [*4] |=> !output_on[0])
    else $error("output resumed above warning");
  resume_on_a: assert property (s_clear6 |-> output_on[0])
    else $error("output did not resume");
  enable_off_a: assert property ($fell(enable_pin[1]) |-> ##[1:5] !output_on[1] [*4])
    else $error("output on with enable low");
endmodule

bind otfrc_pmbus_regs otfrc_assertions #(.RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)) u_chk (
  .sys_clk, .rstn, .scl, .sda_in, .sda_out, .sda_oe_n, .alert_line_n, .enable_pin,
  .ot_fault_in, .ot_warn_in, .output_on, .page_cfg, .vin_ov_threshold
);

`default_nettype wire

// file: otfrc_host.sv
// Management-link host model driving the clock and data lines
`timescale 1ns/1ns
`default_nettype none

module otfrc_host #(
  parameter logic [6:0] ADDR = otfrc_pkg::DEFAULT_SLAVE_ADDR
) (
  input  wire logic sys_clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  int nack_cnt = 0;

  // Clock line idles high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Data moves mid low phase; 8 cycles low and 8 high give the 160 ns period
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    hw(4);
    scl = 1'b1;
    hw(4);
    r = sda;
    hw(4);
    scl = 1'b0;
    hw(4);
  endtask

  task automatic start();
    sda_pull = 1'b0;
    hw(4);
    scl = 1'b1;
    hw(4);
    sda_pull = 1'b1;
    hw(4);
    scl = 1'b0;
    hw(4);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    hw(4);
    scl = 1'b1;
    hw(4);
    sda_pull = 1'b0;
    hw(4);
  endtask

  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nack_cnt++;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n,
                    input logic [6:0] a = ADDR);
    start();
    put({a, 1'b0});
    put(cmd);
    for (int i = 0; i < n; i++) put(d[8*i +: 8]);
    stop();
  endtask

  // Low byte first; the last byte is refused with a high acknowledge bit
  task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] d);
    logic [7:0] b;
    logic       r;
    start();
    put({ADDR, 1'b0});
    put(cmd);
    start();
    put({ADDR, 1'b1});
    d = 16'h0000;
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) bit_io(1'b1, b[j]);
      bit_io(i == n - 1, r);
      d[8*i +: 8] = b;
    end
    stop();
  endtask
endmodule

`default_nettype wire

// file: otfrc_pmbus_regs_tb.sv
// Self-checking bench for the fault response and threshold registers
`timescale 1ns/1ns
`default_nettype none

module otfrc_pmbus_regs_tb;
  localparam int UNIT = 20;
  logic                       sys_clk      = 1'b0;
  logic                       rstn         = 1'b0;
  logic [1:0]                 enable_pin   = 2'h0;
  logic [1:0]                 ot_fault_in  = 2'h0;
  logic [1:0]                 ot_warn_in   = 2'h0;
  logic                       scl;
  logic                       sda;
  logic                       sda_pull;
  logic                       sda_out;
  logic                       sda_oe_n;
  logic                       alert_line_n;
  logic [1:0]                 output_on;
  otfrc_pkg::otfrc_page_cfg_t [1:0] page_cfg;
  otfrc_pkg::otfrc_linear11_t vin_ov_threshold;
  logic [15:0]                rv;
  logic [7:0]                 lat[3]       = '{8'h80, 8'h40, 8'h88};
  logic [7:0]                 rty[2]       = '{8'hb8, 8'hbf};
  int                         k;
  int                         e;
  int                         miscompares  = 0;
  int                         cmp_count    = 0;

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Open-drain data line with pull-up
  assign sda = !(sda_pull || !sda_oe_n);

  otfrc_pmbus_regs #(.RETRY_UNIT_CYCLES(UNIT)) DUT (
    .sys_clk, .rstn, .scl, .sda_in(sda), .sda_out, .sda_oe_n, .alert_line_n, .enable_pin,
    .ot_fault_in, .ot_warn_in, .output_on, .page_cfg, .vin_ov_threshold
  );
  otfrc_host host (.sys_clk, .sda, .scl, .sda_pull);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_on(input int p, input logic v, input int n, output int c);
    c = 0;
    while (output_on[p] !== v && c < n) begin
      cyc(1);
      c++;
    end
    if (output_on[p] !== v) begin
      check(output_on[p], v);
      close_out();
    end
  endtask

  initial begin
    cyc(8);
    rstn = 1'b1;
    cyc(4);
    check({11'h000, output_on, alert_line_n, sda_oe_n, sda_out}, 16'h0006);
    // ----
    // Reset values, then per-page and shared settings
    // ----
    for (int p = 0; p < 2; p++) begin
      host.wr(otfrc_pkg::CMD_PAGE, 16'(p), 1);
      host.rd(otfrc_pkg::CMD_OT_FAULT_ACTION, 1, rv);
      check(rv, 16'h00ff);
      host.rd(otfrc_pkg::CMD_OT_WARN_THRESH, 2, rv);
      check(rv, 16'heb70);
      host.rd(otfrc_pkg::CMD_VIN_OV_THRESH, 2, rv);
      check(rv, 16'hd3e0);
    end
    host.wr(otfrc_pkg::CMD_OT_WARN_THRESH, 16'hf95e, 2);
    check({11'h000, page_cfg[1].warn_threshold.exponent}, 16'h001f);
    check({5'h00, page_cfg[1].warn_threshold.mantissa}, 16'h015e);
    host.rd(otfrc_pkg::CMD_OT_WARN_THRESH, 2, rv);
    check(rv, 16'hf95e);
    host.wr(otfrc_pkg::CMD_VIN_OV_THRESH, 16'hd3a0, 2);
    host.wr(otfrc_pkg::CMD_PAGE, 16'h0000, 1);
    host.rd(otfrc_pkg::CMD_OT_WARN_THRESH, 2, rv);
    check(rv, 16'heb70);
    host.rd(otfrc_pkg::CMD_VIN_OV_THRESH, 2, rv);
    check(rv, 16'hd3a0);
    check(vin_ov_threshold, 16'hd3a0);
    host.wr(otfrc_pkg::CMD_OT_FAULT_ACTION, 16'h0011, 1, otfrc_pkg::DEFAULT_SLAVE_ADDR ^ 7'h01);
    check(16'(host.nack_cnt), 16'h0003);
    check(page_cfg[0].fault_action, 16'h00ff);
    $display("test registers done");
    // ----
    // Latched shutdown codes on page 0
    // ----
    foreach (lat[i]) begin
      host.wr(otfrc_pkg::CMD_OT_FAULT_ACTION, 16'(lat[i]), 1);
      check(page_cfg[0].fault_action, lat[i]);
      enable_pin[0] = 1'b1;
      wait_on(0, 1'b1, 20, k);
      ot_fault_in[0] = 1'b1;
      wait_on(0, 1'b0, 10, k);
      cyc(3);
      check(alert_line_n, 1'b0);
      ot_fault_in[0] = 1'b0;
      cyc(10 * UNIT);
      check(output_on[0], 1'b0);
      host.rd(otfrc_pkg::CMD_STATUS_TEMP, 1, rv);
      check(rv[otfrc_pkg::STATUS_T_OT_FAULT], 1'b1);
      host.wr(otfrc_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0);
      cyc(2);
      check(alert_line_n, 1'b1);
      enable_pin[0] = 1'b0;
      cyc(6);
    end
    $display("test latched done");
    // ----
    // Continuous restart on page 1, then abort by the enable
    // ----
    host.wr(otfrc_pkg::CMD_PAGE, 16'h0001, 1);
    enable_pin[1] = 1'b1;
    foreach (rty[i]) begin
      host.wr(otfrc_pkg::CMD_OT_FAULT_ACTION, 16'(rty[i]), 1);
      wait_on(1, 1'b1, 20, k);
      ot_fault_in[1] = 1'b1;
      wait_on(1, 1'b0, 10, k);
      ot_fault_in[1] = 1'b0;
      wait_on(1, 1'b1, 400, k);
      e = (int'(rty[i][2:0]) + 1) * UNIT;
      check({15'h0000, k >= e - 4 && k <= e + 4}, 16'h0001);
    end
    ot_fault_in[1] = 1'b1;
    wait_on(1, 1'b0, 10, k);
    ot_fault_in[1] = 1'b0;
    cyc(5);
    enable_pin[1] = 1'b0;
    cyc(200);
    check(output_on[1], 1'b0);
    enable_pin[1] = 1'b1;
    wait_on(1, 1'b1, 20, k);
    host.wr(otfrc_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0);
    $display("test retry done");
    // ----
    // Off while hot, warning status on page 0
    // ----
    host.wr(otfrc_pkg::CMD_PAGE, 16'h0000, 1);
    host.wr(otfrc_pkg::CMD_OT_FAULT_ACTION, 16'h00c0, 1);
    enable_pin[0] = 1'b1;
    wait_on(0, 1'b1, 20, k);
    ot_warn_in[0] = 1'b1;
    cyc(6);
    check(alert_line_n, 1'b0);
    host.rd(otfrc_pkg::CMD_STATUS_WORD, 2, rv);
    check(rv[otfrc_pkg::STATUS_WORD_TEMP], 1'b1);
    host.rd(otfrc_pkg::CMD_STATUS_TEMP, 1, rv);
    check(rv[otfrc_pkg::STATUS_T_OT_WARN], 1'b1);
    ot_fault_in[0] = 1'b1;
    wait_on(0, 1'b0, 10, k);
    ot_fault_in[0] = 1'b0;
    cyc(50);
    check(output_on[0], 1'b0);
    ot_warn_in[0] = 1'b0;
    wait_on(0, 1'b1, 10, k);
    host.wr(otfrc_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0);
    cyc(2);
    check(alert_line_n, 1'b1);
    $display("test hold done");
    close_out();
  end
endmodule

`default_nettype wire
